//--- logic/flyback_pkg.sv
// Shared constants, state encoding and tables for the flyback fault supervisor
//
// Behaviour
// - Sample output voltage at demagnetization end instant
// - Quantize sample into bins 0-17, seventeen boundaries
// - Peak-current floor follows bin table, 80-200 mV
// - Three fault classes: latching, non-latching, auto-recovery
// - Latching fault disables gate drive at once
// - Latched state ignores turn-on threshold restarts
// - Latch cleared by supply reset or line removal
// - Non-latching fault: drive off, startup source off
// - Startup source hovers supply between thresholds
// - Fault cleared: restart at turn-on with line good
// - Supply already up: start immediately if line good
// - Auto-recovery fault: drive off, start recovery timer
// - Recovery timer running: startup source hovers supply
// - Timer expired: restart at next turn-on crossing
// - Dropout timer runs while line below stop level
// - Dropout timer expiry declares brownout, controller off
// - Brownout regulates supply until line above start
// - Overload timer integrates; expiry latches or auto-recovers
package flyback_pkg;

    // Clock rate
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;

    // Times in their own units
    localparam int LINE_DROPOUT_MS = 54;
    localparam int AUTO_RECOVERY_MS = 1200;
    localparam int OVERLOAD_MS = 160;

    // Derived cycle counts
    localparam int LINE_DROPOUT_CYC = LINE_DROPOUT_MS * CLK_PER_MS;
    localparam int AUTO_RECOVERY_CYC = AUTO_RECOVERY_MS * CLK_PER_MS;
    localparam int OVERLOAD_CYC = OVERLOAD_MS * CLK_PER_MS;
    localparam int CNT_W = 25;

    // Output-voltage sample in millivolts
    localparam int SAMPLE_W = 14;
    localparam int NUM_BOUNDS = 17;
    localparam int BIN_W = 5;
    localparam int FIRST_BOUND_MV = 1575;
    localparam int SECOND_BOUND_MV = 2000;
    localparam int BOUND_STEP_MV = 500;
    localparam int LAST_BOUND_MV = 9500;

    // Floor width in millivolts
    localparam int FLOOR_W = 8;

    // Floor per bin, bins 0 to 17
    localparam logic [FLOOR_W-1:0] FLOOR_MV [NUM_BOUNDS+1] = '{
        8'h50, 8'h5A, 8'h64, 8'h6E, 8'h78, 8'h7D, 8'h87, 8'h8C, 8'h96,
        8'h9B, 8'hA0, 8'hA5, 8'hAF, 8'hB4, 8'hB9, 8'hBE, 8'hC3, 8'hC8
    };

    // Reset values
    localparam logic [BIN_W-1:0] BIN_RESET = 5'h00;
    localparam logic [FLOOR_W-1:0] FLOOR_RESET = 8'h50;

    // Supervisor states
    typedef enum logic [2:0] {
        ST_POWER_UP = 3'b000,
        ST_RUN = 3'b001,
        ST_LATCHED = 3'b010,
        ST_NON_LATCH = 3'b011,
        ST_AUTO_REC = 3'b100
    } sup_state_type;

endpackage : flyback_pkg

//--- logic/vout_bin_if.sv
// Carrier between supervisor and output-voltage quantizer
`timescale 1ns/1ps
interface vout_bin_if import flyback_pkg::*; ();
    logic take;                  // Sample instant accepted
    logic [SAMPLE_W-1:0] level;  // Sensed output voltage, mV
    logic [BIN_W-1:0] bin;       // Held bin

    modport ctrl (output take, output level, input bin);
    modport quant (input take, input level, output bin);
endinterface : vout_bin_if

//--- logic/vout_quantizer.sv
// Output-voltage bin quantizer with held result
`timescale 1ns/1ps
module vout_quantizer import flyback_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Sample and bin
    vout_bin_if.quant vb
);

    ////////////////////////////////////////////////////////////////////////
    // Boundary comparators
    logic [NUM_BOUNDS-1:0] above; // Thermometer code
    logic [BIN_W-1:0] bin_reg;    // Held bin
    logic [BIN_W-1:0] bin_next;

    // One comparator per boundary
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BOUNDS; gi++) begin : g_bound
            localparam int BOUND = (gi == 0) ? FIRST_BOUND_MV :
                SECOND_BOUND_MV + (gi - 1) * BOUND_STEP_MV;
            assign above[gi] = (vb.level >= SAMPLE_W'(BOUND));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Bin next value
    always_comb begin
        bin_next = bin_reg;
        // Update only at the sample instant
        if (vb.take) begin
            bin_next = BIN_RESET;
            for (int i = 0; i < NUM_BOUNDS; i++) begin
                if (above[i]) begin
                    bin_next = BIN_W'(i + 1);
                end
            end
        end
    end

    // Bin register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bin_reg <= BIN_RESET;
        end else begin
            bin_reg <= bin_next;
        end
    end

    assign vb.bin = bin_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_bin_held: assert property (!vb.take |=> $stable(bin_reg))
        else $error("bin changed without sample");
    a_bin_low: assert property (vb.take && vb.level < SAMPLE_W'(FIRST_BOUND_MV)
        |=> bin_reg == BIN_RESET)
        else $error("low sample not bin 0");
    a_bin_top: assert property (vb.take && vb.level >= SAMPLE_W'(LAST_BOUND_MV)
        |=> bin_reg == BIN_W'(NUM_BOUNDS))
        else $error("high sample not bin 17");

endmodule : vout_quantizer

//--- logic/flyback_fault_supervisor.sv
// Fault classing, startup-source control, timers and peak-current floor
`timescale 1ns/1ps
module flyback_fault_supervisor import flyback_pkg::*; #(
    parameter int DROPOUT_CYC = LINE_DROPOUT_CYC,   // Line dropout period
    parameter int RECOVERY_CYC = AUTO_RECOVERY_CYC, // Auto-recovery period
    parameter int OVLD_CYC = OVERLOAD_CYC           // Overload period
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Supply comparators
    input wire logic vcc_above_on,
    input wire logic vcc_below_off,
    input wire logic vcc_below_reset,
    // Line comparators
    input wire logic line_above_start,
    input wire logic line_below_stop,
    input wire logic line_removal_event,
    // Fault detectors
    input wire logic abnormal_overcurrent_fault,
    input wire logic vcc_overvoltage_fault,
    input wire logic ext_latch_request,
    input wire logic thermal_fault,
    input wire logic overload_detect,
    input wire logic overload_latch_option,
    // Output-voltage sensing
    input wire logic demag_sense_input,
    input wire logic [SAMPLE_W-1:0] vout_sample,
    // Drive and supply control
    output logic drive_enable,
    output logic startup_enable,
    output logic [FLOOR_W-1:0] min_peak_current_floor,
    // Status
    output logic latched_status,
    output logic brownout_status,
    output logic autorec_status
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    sup_state_type state_reg, state_next;  // Supervisor state
    logic drive_reg, drive_next;           // Gate drive enable
    logic hv_reg, hv_next;                 // Startup source enable
    logic vcc_on_prev_reg, vcc_on_prev_next; // Turn-on edge history
    logic [CNT_W-1:0] bo_cnt_reg, bo_cnt_next;   // Dropout timer
    logic bo_reg, bo_next;                 // Brownout flag
    logic [CNT_W-1:0] ar_cnt_reg, ar_cnt_next;   // Recovery timer
    logic ar_done_reg, ar_done_next;       // Recovery expired
    logic [CNT_W-1:0] ov_cnt_reg, ov_cnt_next;   // Overload integrator
    logic [FLOOR_W-1:0] floor_reg, floor_next;   // Current floor
    logic latched_reg, latched_next;       // Latched status flop
    logic autorec_reg, autorec_next;       // Recovery status flop
    logic latch_fault;   // Any latching cause
    logic nonlatch_fault; // Any non-latching cause
    logic ovld_trip;     // Overload integrator expired
    logic vcc_on_rise;   // Turn-on crossing
    logic clear_all;     // Supply reset or line removal
    logic bo_expire;     // Dropout timer reached end

    vout_bin_if vb ();

    ////////////////////////////////////////////////////////////////////////
    // Fault decode
    assign latch_fault = abnormal_overcurrent_fault | vcc_overvoltage_fault |
                         ext_latch_request;
    assign nonlatch_fault = bo_next | thermal_fault;
    assign vcc_on_rise = vcc_above_on & ~vcc_on_prev_reg;
    assign clear_all = vcc_below_reset | line_removal_event;
    assign bo_expire = line_below_stop &&
                       (bo_cnt_reg == CNT_W'(DROPOUT_CYC - 1));
    assign ovld_trip = (state_reg == ST_RUN) && overload_detect &&
                       (ov_cnt_reg == CNT_W'(OVLD_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // Brownout timer next values
    always_comb begin
        bo_cnt_next = bo_cnt_reg;
        bo_next = bo_reg;
        // Count while line is below stop level
        if (line_below_stop) begin
            if (!bo_expire) begin
                bo_cnt_next = bo_cnt_reg + CNT_W'(1);
            end
        end else begin
            bo_cnt_next = '0;
        end
        // Clear when line back above start level
        if (line_above_start) begin
            bo_next = 1'b0;
        end
        // Expiry wins over clear
        if (bo_expire) begin
            bo_next = 1'b1;
        end
    end

    // Brownout timer registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bo_cnt_reg <= '0;
            bo_reg <= 1'b0;
        end else begin
            bo_cnt_reg <= bo_cnt_next;
            bo_reg <= bo_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overload integrator next value
    always_comb begin
        ov_cnt_next = ov_cnt_reg;
        if (state_reg != ST_RUN || ovld_trip) begin
            ov_cnt_next = '0;
        end else if (overload_detect) begin
            ov_cnt_next = ov_cnt_reg + CNT_W'(1);
        end else if (ov_cnt_reg != '0) begin
            ov_cnt_next = ov_cnt_reg - CNT_W'(1);
        end
    end

    // Overload integrator register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ov_cnt_reg <= '0;
        end else begin
            ov_cnt_reg <= ov_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supervisor next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            // Initial power-on: wait for supply and line
            ST_POWER_UP: begin
                if (latch_fault) begin
                    state_next = ST_LATCHED;
                end else if (vcc_above_on && line_above_start &&
                             !nonlatch_fault) begin
                    state_next = ST_RUN;
                end
            end
            // Switching
            ST_RUN: begin
                if (latch_fault || (ovld_trip && overload_latch_option)) begin
                    state_next = ST_LATCHED;
                end else if (nonlatch_fault) begin
                    state_next = ST_NON_LATCH;
                end else if (ovld_trip) begin
                    state_next = ST_AUTO_REC;
                end
            end
            // Latched: only reset or line removal frees it
            ST_LATCHED: begin
                state_next = ST_LATCHED;
            end
            // Restart once cleared, supply up and line good
            ST_NON_LATCH: begin
                if (latch_fault) begin
                    state_next = ST_LATCHED;
                end else if (!nonlatch_fault && vcc_above_on &&
                             line_above_start) begin
                    state_next = ST_RUN;
                end
            end
            // Restart at the turn-on crossing after expiry
            ST_AUTO_REC: begin
                if (latch_fault) begin
                    state_next = ST_LATCHED;
                end else if (ar_done_reg && vcc_on_rise && line_above_start &&
                             !nonlatch_fault) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_POWER_UP;
            end
        endcase
        // Supply reset or line removal restarts the power-on sequence
        if (clear_all) begin
            state_next = ST_POWER_UP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive, startup source and recovery timer next values
    always_comb begin
        drive_next = (state_next == ST_RUN);
        hv_next = hv_reg;
        ar_cnt_next = ar_cnt_reg;
        ar_done_next = ar_done_reg;
        vcc_on_prev_next = vcc_above_on;
        // Status flags registered from the next state
        latched_next = (state_next == ST_LATCHED);
        autorec_next = (state_next == ST_AUTO_REC);
        if (state_next == ST_RUN) begin
            // Aux winding supplies the part while switching
            hv_next = 1'b0;
        end else if (state_reg == ST_RUN) begin
            // Fault entry: let supply decay first
            hv_next = 1'b0;
        end else if (vcc_below_off) begin
            hv_next = 1'b1;
        end else if (vcc_above_on) begin
            hv_next = 1'b0;
        end
        // Recovery timer runs only in its state
        if (state_next == ST_AUTO_REC && state_reg != ST_AUTO_REC) begin
            ar_cnt_next = '0;
            ar_done_next = 1'b0;
        end else if (state_reg == ST_AUTO_REC && !ar_done_reg) begin
            if (ar_cnt_reg == CNT_W'(RECOVERY_CYC - 1)) begin
                ar_done_next = 1'b1;
            end else begin
                ar_cnt_next = ar_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Supervisor registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_POWER_UP;
            drive_reg <= 1'b0;
            hv_reg <= 1'b1;
            ar_cnt_reg <= '0;
            ar_done_reg <= 1'b0;
            vcc_on_prev_reg <= 1'b0;
            latched_reg <= 1'b0;
            autorec_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            drive_reg <= drive_next;
            hv_reg <= hv_next;
            ar_cnt_reg <= ar_cnt_next;
            ar_done_reg <= ar_done_next;
            vcc_on_prev_reg <= vcc_on_prev_next;
            latched_reg <= latched_next;
            autorec_reg <= autorec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output-voltage sampling and floor
    // Take sample only while switching
    assign vb.take = demag_sense_input & drive_reg;
    assign vb.level = vout_sample;

    vout_quantizer u_quant (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .vb (vb)
    );

    // Floor lookup from held bin
    always_comb begin
        floor_next = FLOOR_MV[vb.bin];
    end

    // Floor register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            floor_reg <= FLOOR_RESET;
        end else begin
            floor_reg <= floor_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign drive_enable = drive_reg;
    assign startup_enable = hv_reg;
    assign min_peak_current_floor = floor_reg;
    assign latched_status = latched_reg;
    assign brownout_status = bo_reg;
    assign autorec_status = autorec_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_latch_drive_off: assert property (latch_fault |=> !drive_enable)
        else $error("drive stayed on after latching fault");
    a_latch_no_restart: assert property (state_reg == ST_LATCHED && !clear_all
        |=> latched_status && !drive_enable)
        else $error("latched state restarted");
    a_latch_clear: assert property (latched_status && clear_all
        |=> !latched_status)
        else $error("latch not cleared");
    a_nonlatch_off: assert property (state_reg == ST_RUN && thermal_fault &&
        !latch_fault && !clear_all && !ovld_trip |=> !drive_enable && !startup_enable
        && state_reg == ST_NON_LATCH)
        else $error("non-latching entry wrong");
    a_hv_charge: assert property (state_reg inside {ST_NON_LATCH, ST_AUTO_REC}
        && state_next == state_reg && vcc_below_off |=> startup_enable)
        else $error("startup source not on at turn-off");
    a_hv_stop: assert property (state_reg == ST_AUTO_REC && state_next ==
        ST_AUTO_REC && vcc_above_on && !vcc_below_off
        |=> !startup_enable)
        else $error("startup source not off at turn-on");
    a_nl_restart: assert property (state_reg == ST_NON_LATCH && !latch_fault
        && !clear_all && !nonlatch_fault && vcc_above_on && line_above_start
        |=> drive_enable)
        else $error("no restart after fault cleared");
    a_nl_no_line: assert property (state_reg == ST_NON_LATCH &&
        !line_above_start |=> !drive_enable)
        else $error("restart without good line");
    a_ar_hold: assert property ($rose(autorec_status)
        |-> !drive_enable [*8])
        else $error("drive during recovery timer");
    a_ar_edge: assert property (state_reg == ST_AUTO_REC && !vcc_on_rise
        |=> !drive_enable)
        else $error("recovery start without turn-on crossing");
    a_bo_cause: assert property ($rose(brownout_status)
        |-> $past(line_below_stop))
        else $error("brownout without line dropout");
    a_bo_stop: assert property ($rose(brownout_status) && !clear_all &&
        $past(state_reg == ST_RUN) |-> !drive_enable)
        else $error("switching continued in brownout");
    a_ovld_trip: assert property (ovld_trip && !latch_fault && !clear_all
        |=> overload_latch_option ? latched_status :
        (autorec_status || state_reg == ST_NON_LATCH))
        else $error("overload trip not handled");
    a_floor_map: assert property (1'b1 |=> min_peak_current_floor ==
        FLOOR_MV[$past(vb.bin)])
        else $error("floor does not follow bin");

    c_latched: cover property (state_reg == ST_RUN ##1 latched_status);
    c_ar_restart: cover property (autorec_status ##1 drive_enable);
    c_brownout: cover property (brownout_status ##[1:20] drive_enable);

endmodule : flyback_fault_supervisor

//--- bench/supply_model.sv
// Supply rail and comparator model of the flyback power stage
`timescale 1ns/1ps
module supply_model (
    // Clock
    input wire logic sys_clk,
    // Controls from supervisor and bench
    input wire logic drive_enable,
    input wire logic startup_enable,
    input wire logic hold_vcc,
    input wire logic collapse,
    // Comparator decisions
    output logic vcc_above_on,
    output logic vcc_below_off,
    output logic vcc_below_reset
);
    int vcc = 0; // Rail level in model units

    // Rail starts discharged
    initial begin
        vcc_above_on = 1'b0;
        vcc_below_off = 1'b1;
        vcc_below_reset = 1'b1;
    end

    // Rail moves at the falling edge, away from the sampling edge
    always @(negedge sys_clk) begin
        if (collapse) begin
            // Rail pulled down hard, beats the startup source
            vcc = (vcc > 4) ? vcc - 4 : 0;
        end else if (startup_enable) begin
            // Startup source charges the rail
            vcc = (vcc < 100) ? vcc + 2 : vcc;
        end else if (!(drive_enable || hold_vcc) && vcc > 0) begin
            // Own consumption drains an unfed rail
            vcc = vcc - 1;
        end
        vcc_above_on = (vcc >= 80);
        vcc_below_off = (vcc < 40);
        vcc_below_reset = (vcc < 10);
    end
endmodule : supply_model

//--- bench/flyback_fault_supervisor_tb.sv
// Self-checking bench for the flyback fault supervisor
`timescale 1ns/1ps
module flyback_fault_supervisor_tb import flyback_pkg::*;;
    localparam int DROP = 20; // Short dropout period
    localparam int RECOV = 40; // Short recovery period
    localparam int OVLD = 30; // Short overload period
    logic sys_clk = 1'b0;
    logic reset_n = 1'b1;
    logic line_above_start = 1'b1, line_below_stop = 1'b0, line_removal_event = 1'b0;
    logic [2:0] latch_src = 3'h0; // Latching fault causes
    logic thermal_fault = 1'b0, overload_detect = 1'b0, overload_latch_option = 1'b0;
    logic demag_sense_input = 1'b0, hold_vcc = 1'b0, collapse = 1'b0;
    logic [SAMPLE_W-1:0] vout_sample = 14'h0000;
    logic vcc_above_on, vcc_below_off, vcc_below_reset;
    logic drive_enable, startup_enable, latched_status, brownout_status, autorec_status;
    logic [FLOOR_W-1:0] min_peak_current_floor;
    int miscompares = 0, tests_run = 0, n = 0, m = 0, lo = 0;
    int exp_floor = 80; // Model of the held floor
    int floor_tbl[18] = '{80, 90, 100, 110, 120, 125, 135, 140, 150, 155, 160, 165, 175,
        180, 185, 190, 195, 200};
    logic [31:0] rnd = 32'h0000BF53; // Random state

    // Free-running clock
    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////
    flyback_fault_supervisor #(.DROPOUT_CYC(DROP), .RECOVERY_CYC(RECOV), .OVLD_CYC(OVLD)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .vcc_above_on(vcc_above_on),
        .vcc_below_off(vcc_below_off), .vcc_below_reset(vcc_below_reset),
        .line_above_start(line_above_start), .line_below_stop(line_below_stop),
        .line_removal_event(line_removal_event), .abnormal_overcurrent_fault(latch_src[0]),
        .vcc_overvoltage_fault(latch_src[1]), .ext_latch_request(latch_src[2]),
        .thermal_fault(thermal_fault), .overload_detect(overload_detect),
        .overload_latch_option(overload_latch_option), .demag_sense_input(demag_sense_input),
        .vout_sample(vout_sample), .drive_enable(drive_enable),
        .startup_enable(startup_enable), .min_peak_current_floor(min_peak_current_floor),
        .latched_status(latched_status), .brownout_status(brownout_status),
        .autorec_status(autorec_status));
    supply_model supply_u (.sys_clk(sys_clk), .drive_enable(drive_enable),
        .startup_enable(startup_enable), .hold_vcc(hold_vcc), .collapse(collapse),
        .vcc_above_on(vcc_above_on), .vcc_below_off(vcc_below_off),
        .vcc_below_reset(vcc_below_reset));

    ////////////////////////////////////////
    // Expected bin, upper bin at a boundary
    function automatic int ref_bin(input int v);
        if (v < 1575) return 0;
        if (v < 2000) return 1;
        return (v >= 9500) ? 17 : 2 + (v - 2000) / 500;
    endfunction : ref_bin

    // Random step
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift

    // Pick a watched output
    function automatic logic sel(input int w);
        case (w)
            0: return drive_enable;
            1: return startup_enable;
            2: return latched_status;
            3: return brownout_status;
            default: return autorec_status;
        endcase
    endfunction : sel

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // Falling edges
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc

    // Bounded wait for an output level, cycles waited in n
    task automatic wait_sig(input int w, input logic v, input int lim);
        n = 0;
        while (sel(w) !== v && n < lim) begin
            cyc(1);
            n++;
        end
        check(sel(w), v);
    endtask : wait_sig

    // Count cycles with drive on
    task automatic count_drive(input int k);
        m = 0;
        repeat (k) begin
            cyc(1);
            if (drive_enable !== 1'b0) m++;
        end
    endtask : count_drive

    // One sample pulse, then floor compare
    task automatic sample(input int v);
        if (drive_enable === 1'b1) exp_floor = floor_tbl[ref_bin(v)];
        demag_sense_input = 1'b1;
        vout_sample = v[SAMPLE_W-1:0];
        cyc(1);
        demag_sense_input = 1'b0;
        cyc(2);
        check(min_peak_current_floor, exp_floor[7:0]);
    endtask : sample

    // Drop the rail below reset, then restart
    task automatic clear_latch;
        collapse = 1'b1;
        wait_sig(2, 1'b0, 100);
        collapse = 1'b0;
        wait_sig(0, 1'b1, 400);
    endtask : clear_latch

    // Verdict and stop
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_of_test;
    end

    // Main sequence
    initial begin
        #1 reset_n = 1'b0;
        cyc(2);
        check({drive_enable, startup_enable, min_peak_current_floor}, 10'h150);
        reset_n = 1'b1;
        wait_sig(0, 1'b1, 200);
        // Every bin, random inside; bins 1 to 17 also at their lower boundary
        for (int b = 0; b < 18; b++) begin
            rnd = xorshift(rnd);
            lo = (b == 0) ? 0 : (b == 1) ? 1575 : 2000 + 500 * (b - 2);
            sample(lo + int'(rnd[15:0]) % ((b == 1) ? 425 : 500));
            if (b > 0) sample(lo);
        end
        // Each latching cause
        for (int i = 0; i < 3; i++) begin
            latch_src[i] = 1'b1;
            cyc(1);
            check({drive_enable, latched_status}, 2'b01);
            latch_src[i] = 1'b0;
            count_drive(150);
            check(m[15:0], 16'h0000);
            if (i == 2) begin
                line_removal_event = 1'b1;
                cyc(1);
                check(latched_status, 1'b0);
                line_removal_event = 1'b0;
                wait_sig(0, 1'b1, 400);
            end else begin
                clear_latch;
            end
        end
        // Thermal fault, held floor, hover, immediate start
        thermal_fault = 1'b1;
        cyc(1);
        check({drive_enable, startup_enable}, 2'b00);
        sample(0);
        wait_sig(1, 1'b1, 100);
        check(drive_enable, 1'b0);
        hold_vcc = 1'b1;
        wait_sig(1, 1'b0, 100);
        thermal_fault = 1'b0;
        cyc(2);
        check(drive_enable, 1'b1);
        hold_vcc = 1'b0;
        // Short dip ignored, long dip is a brownout
        line_below_stop = 1'b1;
        cyc(DROP - 5);
        line_below_stop = 1'b0;
        cyc(2);
        check({brownout_status, drive_enable}, 2'b01);
        line_below_stop = 1'b1;
        line_above_start = 1'b0;
        wait_sig(3, 1'b1, 100);
        check(n >= DROP - 1 && n <= DROP + 2, 1'b1);
        count_drive(150);
        check(m[15:0], 16'h0000);
        line_below_stop = 1'b0;
        line_above_start = 1'b1;
        wait_sig(3, 1'b0, 5);
        wait_sig(0, 1'b1, 300);
        // Overload integrates up and down, then auto-recovers
        overload_detect = 1'b1;
        cyc(20);
        overload_detect = 1'b0;
        cyc(10);
        overload_detect = 1'b1;
        wait_sig(4, 1'b1, 100);
        check(n >= OVLD - 11 && n <= OVLD - 8, 1'b1);
        check(drive_enable, 1'b0);
        overload_detect = 1'b0;
        wait_sig(1, 1'b1, 100);
        m = n;
        wait_sig(0, 1'b1, 400);
        check(m + n >= RECOV, 1'b1);
        // Overload with the latch option
        overload_latch_option = 1'b1;
        overload_detect = 1'b1;
        wait_sig(2, 1'b1, 100);
        overload_detect = 1'b0;
        clear_latch;
        end_of_test;
    end
endmodule : flyback_fault_supervisor_tb
